// ===== fcp_consts.svh
// Purpose: Named constants for the dual mode flash command port.
// Assumes: A 20 MHz system clock.
// Notes:   Included by every design file that needs a number.
`ifndef FCP_CONSTS_SVH
`define FCP_CONSTS_SVH
`define FCP_CLK_NS        50
`define FCP_PAGE_TRANSFER_TIME_NS      500000
`define FCP_T_PROG_NS     50000000
`define FCP_OP_BUF1_SER   8'hd4
`define FCP_OP_BUF2_SER   8'hd6
`define FCP_OP_BUF1_BYTE  8'h54
`define FCP_OP_BUF2_BYTE  8'h56
`define FCP_OP_ARRAY      8'he8
`define FCP_OP_PAGE       8'hd2
`define FCP_OP_STATUS     8'hd7
`define FCP_OP_ID         8'h9f
`define FCP_OP_XFR1       8'h53
`define FCP_OP_XFR2       8'h55
`define FCP_OP_CMP1       8'h60
`define FCP_OP_CMP2       8'h61
`define FCP_OP_PROG1      8'h83
`define FCP_OP_PROG2      8'h86
`define FCP_OP_FPROG1     8'h88
`define FCP_OP_FPROG2     8'h89
`define FCP_ADDR_BYTES    3'h4
`define FCP_DUMMY_BUF     3'h1
`define FCP_DUMMY_ARRAY   3'h4
`define FCP_BYTE_LAST     11'h41f
`define FCP_IDLE_BYTE     8'hff
`define FCP_PAGE_LSB      11
`define FCP_PAGE_MSB      24
`define FCP_SEC_LOW_MSB   10
`define FCP_SEC_SEL_LSB   5
`define FCP_ID_LAST       2'h3
`endif

// ===== fcp_pkg.sv
// Purpose: Types shared by the command port modules.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package fcp_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_OUT, ST_IGNORE} fcp_state_t;
   typedef enum logic [3:0] {OP_BUF1, OP_BUF2, OP_ARRAY, OP_PAGE, OP_STAT, OP_ID,
                             OP_XFR, OP_PROG, OP_OTHER} fcp_op_t;
endpackage : fcp_pkg

// ===== fcp_stream_if.sv
// Purpose: Byte stream with valid and ready between the port and its FIFO.
// Assumes: One clock for both ends.
// Notes:   A word moves when valid and ready are both high.
`timescale 1ns/10ps
interface fcp_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : fcp_stream_if

// ===== fcp_fifo.sv
// Purpose: Small synchronous FIFO on the read data path.
// Assumes: Depth is a power of two.
// Notes:   Flush empties it in one cycle.
`timescale 1ns/10ps
module fcp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic  i_clk,
   input  wire logic  i_rst_n,
   input  wire logic  i_flush,
   fcp_stream_if.snk  wr,
   fcp_stream_if.src  rd
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          push, pop;

   assign wr.ready = (cnt_r != D[AW:0]);
   assign rd.valid = (cnt_r != '0);
   assign rd.data  = mem[rp_r];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   always_comb begin
      wp_nxt  = push ? wp_r + 1'b1 : wp_r;
      rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (i_flush) begin
         wp_nxt  = '0;
         rp_nxt  = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_r] <= wr.data;
      end
   end
endmodule : fcp_fifo

// ===== fcp_cmd_port.sv
// Purpose: Command port of a serial or byte wide flash memory, device side.
// Assumes: Link clock, select and data pins are asynchronous and are synchronised.
// Notes:   Array and buffer data come from a memory port; the FIFO hides its latency.
//
// Contract
// - Frames start whether the link clock idles low or high at select fall.
// - Serial output bit changes after a falling edge, valid in the high phase.
// - Byte wide mode works with both clock idle levels.
// - Serial buffer read uses opcode D4 or D6, then address, one dummy byte, then data.
// - Byte wide buffer read uses 54 or 56; bus stays undriven until data.
// - Opcode 9F returns identification bytes without any address.
// - Opcode E8 reads continuously across pages from a start address.
// - Opcode D2 reads one main memory page directly, wrapping in the page.
// - Opcode D7 returns the status byte without any address.
// - Page bits 13..3 zero give sector 0, else top six bits plus one.
// - Page transfer or compare holds busy for at most 500 us.
// - Busy goes low within 150 ns after select rises on timed commands.
`timescale 1ns/10ps
`include "fcp_consts.svh"
module fcp_cmd_port import fcp_pkg::*; #(
   parameter int         XFR_CYCLES  = `FCP_PAGE_TRANSFER_TIME_NS / `FCP_CLK_NS,
   parameter int         PROG_CYCLES = `FCP_T_PROG_NS / `FCP_CLK_NS,
   parameter logic [7:0] ID_MAKER    = 8'h5a, // Arbitrary value.
   parameter logic [7:0] ID_PART1    = 8'h11, // Arbitrary value.
   parameter logic [7:0] ID_PART2    = 8'h22, // Arbitrary value.
   parameter logic [7:0] ID_EXTRA    = 8'h00,
   parameter logic [6:0] STATUS_LOW  = 7'h3c
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RESETN,
   input  wire logic        I_CS_N,
   input  wire logic        I_SCK,
   input  wire logic        I_SI,
   input  wire logic [7:0]  I_BUS,
   input  wire logic        I_IFSEL_BYTE,
   input  wire logic        I_MEM_ACK,
   input  wire logic [7:0]  I_MEM_DATA,
   output logic             O_SO,
   output logic             O_SO_OE,
   output logic [7:0]       O_BUS,
   output logic             O_BUS_OE,
   output logic             O_RDY_BUSY_N,
   output logic             O_MEM_REQ,
   output logic [1:0]       O_MEM_SRC,
   output logic [24:0]      O_MEM_ADDR,
   output logic [6:0]       O_SECTOR
);
   // ****************************************
   // Functions.
   // ****************************************
   function automatic fcp_op_t op_class(input logic [7:0] op, input logic byte_mode);
      fcp_op_t c;
      c = OP_OTHER;
      case (op)
         `FCP_OP_BUF1_SER:  c = byte_mode ? OP_OTHER : OP_BUF1;
         `FCP_OP_BUF2_SER:  c = byte_mode ? OP_OTHER : OP_BUF2;
         `FCP_OP_BUF1_BYTE: c = byte_mode ? OP_BUF1 : OP_OTHER;
         `FCP_OP_BUF2_BYTE: c = byte_mode ? OP_BUF2 : OP_OTHER;
         `FCP_OP_ARRAY:     c = OP_ARRAY;
         `FCP_OP_PAGE:      c = OP_PAGE;
         `FCP_OP_STATUS:    c = OP_STAT;
         `FCP_OP_ID:        c = OP_ID;
         `FCP_OP_XFR1, `FCP_OP_XFR2, `FCP_OP_CMP1, `FCP_OP_CMP2: c = OP_XFR;
         `FCP_OP_PROG1, `FCP_OP_PROG2, `FCP_OP_FPROG1, `FCP_OP_FPROG2: c = OP_PROG;
         default:           c = OP_OTHER;
      endcase
      return c;
   endfunction : op_class

   function automatic logic [6:0] sector_of(input logic [13:0] page);
      if (page[13:3] == 11'h000) begin
         return 7'h00;
      end
      return {1'b0, page[13:8]} + 7'h01;
   endfunction : sector_of

   // ****************************************
   // Pin synchronisers and edge detection.
   // ****************************************
   logic       cs_m, cs_s, cs_d, sck_m, sck_s, sck_d, si_m, si_s, ifs_m, ifs_s;
   logic [7:0] bus_m, bus_s;
   logic       cs_fall, cs_rise, rise, fall;

   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         {cs_m, cs_s, cs_d}    <= 3'h7;
         {sck_m, sck_s, sck_d} <= 3'h0;
         {si_m, si_s, ifs_m, ifs_s} <= 4'h0;
         bus_m <= 8'h00;
         bus_s <= 8'h00;
      end else begin
         cs_m  <= I_CS_N;
         cs_s  <= cs_m;
         cs_d  <= cs_s;
         sck_m <= I_SCK;
         sck_s <= sck_m;
         sck_d <= sck_s;
         si_m  <= I_SI;
         si_s  <= si_m;
         ifs_m <= I_IFSEL_BYTE;
         ifs_s <= ifs_m;
         bus_m <= I_BUS;
         bus_s <= bus_m;
      end
   end

   assign cs_fall = cs_d && !cs_s;
   assign cs_rise = !cs_d && cs_s;
   assign rise    = !cs_s && sck_s && !sck_d;
   assign fall    = !cs_s && !sck_s && sck_d;

   // ****************************************
   // Frame control.
   // ****************************************
   fcp_stream_if #(.W(8)) fill ();
   fcp_stream_if #(.W(8)) drain ();

   fcp_state_t  state_r, state_nxt;
   logic [7:0]  opc_r, opc_nxt, shift_r, shift_nxt, tx_r, tx_nxt, bus_r, bus_nxt, rx;
   logic [23:0] addr_r, addr_nxt;
   logic [24:0] full_addr, mem_addr_r, mem_addr_nxt;
   logic [2:0]  bit_r, bit_nxt, cnt_r, cnt_nxt, dummy;
   logic [1:0]  pend_r, pend_nxt, id_r, id_nxt;
   logic [23:0] busy_r, busy_nxt;
   logic [6:0]  sector_r, sector_nxt;
   logic        bmode_r, bmode_nxt, so_r, so_nxt, so_oe_r, so_oe_nxt, bus_oe_r, bus_oe_nxt;
   logic        unit_done, mem_op, out_unit;
   fcp_op_t     cls, cur;

   assign rx        = bmode_r ? bus_s : {shift_r[6:0], si_s};
   assign unit_done = rise && (bmode_r || bit_r == 3'h7);
   assign cls       = op_class(rx, bmode_r);
   assign cur       = op_class(opc_r, bmode_r);
   assign full_addr = {addr_r[16:0], rx};
   assign mem_op    = (cur == OP_BUF1) || (cur == OP_BUF2) ||
                      (cur == OP_ARRAY) || (cur == OP_PAGE);
   assign out_unit  = fall && state_r == ST_OUT && (bmode_r || bit_r == 3'h0);
   assign dummy     = (cur == OP_BUF1 || cur == OP_BUF2) ? `FCP_DUMMY_BUF : `FCP_DUMMY_ARRAY;

   always_comb begin
      state_nxt = state_r;  opc_nxt = opc_r;      shift_nxt = shift_r;  tx_nxt = tx_r;
      bus_nxt = bus_r;      addr_nxt = addr_r;    mem_addr_nxt = mem_addr_r;
      bit_nxt = bit_r;      cnt_nxt = cnt_r;      pend_nxt = pend_r;    id_nxt = id_r;
      sector_nxt = sector_r; bmode_nxt = bmode_r; so_nxt = so_r;
      so_oe_nxt = so_oe_r;  bus_oe_nxt = bus_oe_r;
      busy_nxt = (busy_r != 24'h0) ? busy_r - 24'h1 : busy_r;
      if (fill.valid && fill.ready && cur == OP_ID && id_r != `FCP_ID_LAST) begin
         id_nxt = id_r + 2'h1;
      end
      if (O_MEM_REQ && I_MEM_ACK) begin
         mem_addr_nxt = mem_addr_r + 25'h1;
         if (mem_addr_r[10:0] == `FCP_BYTE_LAST) begin
            mem_addr_nxt[10:0] = 11'h000;
            mem_addr_nxt[`FCP_PAGE_MSB:`FCP_PAGE_LSB] = mem_addr_r[`FCP_PAGE_MSB:`FCP_PAGE_LSB]
               + ((cur == OP_ARRAY) ? 14'h0001 : 14'h0000);
         end
      end
      if (cs_fall) begin
         state_nxt = ST_OPC;
         bmode_nxt = ifs_s;
         bit_nxt   = 3'h0;
         cnt_nxt   = 3'h0;
         pend_nxt  = 2'h0;
         id_nxt    = 2'h0;
      end else if (cs_rise) begin
         state_nxt  = ST_IDLE;
         so_oe_nxt  = 1'b0;
         bus_oe_nxt = 1'b0;
         if (pend_r == 2'h1) begin
            busy_nxt = XFR_CYCLES[23:0];
         end else if (pend_r == 2'h2) begin
            busy_nxt = PROG_CYCLES[23:0];
         end
      end else if (rise && state_r != ST_OUT && state_r != ST_IDLE) begin
         shift_nxt = rx;
         bit_nxt   = bit_r + 3'h1;
         if (unit_done) begin
            bit_nxt = 3'h0;
            case (state_r)
               ST_OPC: begin
                  opc_nxt   = rx;
                  cnt_nxt   = 3'h0;
                  state_nxt = (cls inside {OP_STAT, OP_ID}) ? ST_OUT : ST_ADDR;
                  pend_nxt  = (cls == OP_XFR) ? 2'h1 : (cls == OP_PROG) ? 2'h2 : 2'h0;
               end
               ST_ADDR: begin
                  addr_nxt = full_addr[23:0];
                  cnt_nxt  = cnt_r + 3'h1;
                  if (cnt_r == `FCP_ADDR_BYTES - 3'h1) begin
                     cnt_nxt      = 3'h0;
                     mem_addr_nxt = full_addr;
                     sector_nxt   = sector_of(full_addr[`FCP_PAGE_MSB:`FCP_PAGE_LSB]);
                     state_nxt    = mem_op ? ST_DUMMY : ST_IGNORE;
                  end
               end
               ST_DUMMY: begin
                  cnt_nxt = cnt_r + 3'h1;
                  if (cnt_r == dummy - 3'h1) begin
                     state_nxt = ST_OUT;
                  end
               end
               default: begin
                  state_nxt = state_r;
               end
            endcase
         end
      end else if (fall && state_r == ST_OUT) begin
         if (bmode_r) begin
            bus_nxt    = drain.valid ? drain.data : `FCP_IDLE_BYTE;
            bus_oe_nxt = 1'b1;
         end else begin
            bit_nxt   = bit_r + 3'h1;
            so_oe_nxt = 1'b1;
            if (bit_r == 3'h0) begin
               tx_nxt = drain.valid ? drain.data : `FCP_IDLE_BYTE;
               so_nxt = tx_nxt[7];
               tx_nxt = {tx_nxt[6:0], 1'b0};
            end else begin
               so_nxt = tx_r[7];
               tx_nxt = {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         state_r <= ST_IDLE;  opc_r <= 8'h00;   shift_r <= 8'h00;   tx_r <= 8'h00;
         bus_r <= 8'h00;      addr_r <= 24'h0;  mem_addr_r <= 25'h0;
         bit_r <= 3'h0;       cnt_r <= 3'h0;    pend_r <= 2'h0;     id_r <= 2'h0;
         busy_r <= 24'h0;     sector_r <= 7'h00; bmode_r <= 1'b0;   so_r <= 1'b0;
         so_oe_r <= 1'b0;     bus_oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt; opc_r <= opc_nxt; shift_r <= shift_nxt; tx_r <= tx_nxt;
         bus_r <= bus_nxt;     addr_r <= addr_nxt; mem_addr_r <= mem_addr_nxt;
         bit_r <= bit_nxt;     cnt_r <= cnt_nxt;  pend_r <= pend_nxt;  id_r <= id_nxt;
         busy_r <= busy_nxt;   sector_r <= sector_nxt; bmode_r <= bmode_nxt; so_r <= so_nxt;
         so_oe_r <= so_oe_nxt; bus_oe_r <= bus_oe_nxt;
      end
   end

   // ****************************************
   // Read data sources and FIFO.
   // ****************************************
   always_comb begin
      fill.valid = 1'b0;
      fill.data  = 8'h00;
      if (state_r == ST_OUT && !cs_s) begin
         case (cur)
            OP_STAT: begin
               fill.valid = 1'b1;
               fill.data  = {(busy_r == 24'h0), STATUS_LOW};
            end
            OP_ID: begin
               fill.valid = 1'b1;
               case (id_r)
                  2'h0:    fill.data = ID_MAKER;
                  2'h1:    fill.data = ID_PART1;
                  2'h2:    fill.data = ID_PART2;
                  default: fill.data = ID_EXTRA;
               endcase
            end
            default: begin
               fill.valid = mem_op && I_MEM_ACK;
               fill.data  = I_MEM_DATA;
            end
         endcase
      end
   end

   assign drain.ready = out_unit && !cs_rise;

   fcp_fifo #(.W(8), .D(8)) u_fifo (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RESETN),
      .i_flush (cs_fall || cs_rise),
      .wr      (fill),
      .rd      (drain)
   );

   assign O_MEM_REQ    = state_r == ST_OUT && !cs_s && mem_op && fill.ready;
   assign O_MEM_SRC    = (cur == OP_BUF1) ? 2'h0 : (cur == OP_BUF2) ? 2'h1 : 2'h2;
   assign O_MEM_ADDR   = mem_addr_r;
   assign O_SECTOR     = sector_r;
   assign O_SO         = so_r;
   assign O_SO_OE      = so_oe_r;
   assign O_BUS        = bus_r;
   assign O_BUS_OE     = bus_oe_r;
   assign O_RDY_BUSY_N = (busy_r == 24'h0);
endmodule : fcp_cmd_port

// ===== fcp_cmd_port_assertions.sv
// Purpose: Pin level checks of the flash command port.
// Assumes: One clock domain, I_MCLK, synchronous reset.
// Notes:   Bound to every fcp_cmd_port instance.
`timescale 1ns/10ps
module fcp_cmd_port_assertions #(
   parameter int XFR_CYCLES  = 20,
   parameter int PROG_CYCLES = 40
) (
   input  wire logic        I_MCLK,
   input  wire logic        I_RESETN,
   input  wire logic        I_CS_N,
   input  wire logic        I_SCK,
   input  wire logic        I_MEM_ACK,
   input  wire logic        O_SO,
   input  wire logic        O_SO_OE,
   input  wire logic [7:0]  O_BUS,
   input  wire logic        O_BUS_OE,
   input  wire logic        O_RDY_BUSY_N,
   input  wire logic        O_MEM_REQ,
   input  wire logic [1:0]  O_MEM_SRC,
   input  wire logic [24:0] O_MEM_ADDR
);
   // ***************************************************************
   // Busy length counter and properties.
   // ***************************************************************
   logic [31:0] bcnt_r;
   logic [31:0] bcnt_nxt;
   logic        take;
   assign take = O_MEM_REQ && I_MEM_ACK;
   always_comb begin
      bcnt_nxt = O_RDY_BUSY_N ? 32'h0 : bcnt_r + 32'h1;
   end
   always_ff @(posedge I_MCLK) begin
      bcnt_r <= I_RESETN ? bcnt_nxt : 32'h0;
   end
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);
   property p_excl; !(O_SO_OE && O_BUS_OE); endproperty
   a_excl: assert property (p_excl) else $error("both outputs on");
   property p_idle; I_CS_N [*6] |-> !O_SO_OE && !O_BUS_OE && !O_MEM_REQ; endproperty
   a_idle: assert property (p_idle) else $error("active while deselected");
   property p_bgo; $fell(O_RDY_BUSY_N) |-> I_CS_N && !$past(I_CS_N, 4); endproperty
   a_bgo: assert property (p_bgo) else $error("busy late");
   property p_bmin; $fell(O_RDY_BUSY_N) |=> !O_RDY_BUSY_N [*8]; endproperty
   a_bmin: assert property (p_bmin) else $error("busy too short");
   property p_bmax; bcnt_r <= PROG_CYCLES + 1; endproperty
   a_bmax: assert property (p_bmax) else $error("busy too long");
   property p_so; O_SO_OE && $past(O_SO_OE) && $changed(O_SO) |-> !I_SCK; endproperty
   a_so: assert property (p_so) else $error("serial out moved in high phase");
   property p_bus; O_BUS_OE && $past(O_BUS_OE) && $changed(O_BUS) |-> !I_SCK; endproperty
   a_bus: assert property (p_bus) else $error("bus out moved in high phase");
   property p_step;
      take && O_MEM_ADDR[10:0] != 11'h41f |=> O_MEM_ADDR == $past(O_MEM_ADDR) + 25'h1;
   endproperty
   a_step: assert property (p_step) else $error("address did not step");
   property p_wrap;
      take && O_MEM_SRC != 2'h2 && O_MEM_ADDR[10:0] == 11'h41f
         |=> O_MEM_ADDR[10:0] == 11'h0 && $stable(O_MEM_ADDR[24:11]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("buffer did not wrap");
endmodule : fcp_cmd_port_assertions
bind fcp_cmd_port fcp_cmd_port_assertions #(.XFR_CYCLES(XFR_CYCLES), .PROG_CYCLES(PROG_CYCLES))
   i_fcp_cmd_port_assertions (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_CS_N(I_CS_N),
   .I_SCK(I_SCK), .I_MEM_ACK(I_MEM_ACK), .O_SO(O_SO), .O_SO_OE(O_SO_OE), .O_BUS(O_BUS),
   .O_BUS_OE(O_BUS_OE), .O_RDY_BUSY_N(O_RDY_BUSY_N), .O_MEM_REQ(O_MEM_REQ),
   .O_MEM_SRC(O_MEM_SRC), .O_MEM_ADDR(O_MEM_ADDR));

// ===== fcp_host.sv
// Purpose: Host controller model driving the command port pins.
// Assumes: Link clock of 400 ns period, made only inside frames.
// Notes:   Released data lines carry the inverse of their last value.
`timescale 1ns/10ps
module fcp_host (
   output logic            o_cs_n,
   output logic            o_sck,
   output logic            o_si,
   output logic [7:0]      o_bus,
   output logic            o_sel,
   input  wire logic       i_so,
   input  wire logic [7:0] i_bus
);
   // ***************************************************************
   // Frame tasks.
   // ***************************************************************
   logic       idle;
   logic [7:0] last;
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
      o_bus  = 8'h00;
      o_sel  = 1'b0;
      last   = 8'h00;
   end
   task open(input logic hi, input logic bm);
      idle   = hi;
      o_sel  = bm;
      o_sck  = hi;
      #100;
      o_cs_n = 1'b0;
      #250;
   endtask : open
   task xb(input logic [7:0] d, output logic [7:0] q);
      last = d;
      for (int i = 7; i >= (o_sel ? 7 : 0); i--) begin
         o_sck = 1'b0;
         o_si  = d[i];
         o_bus = d;
         #200;
         o_sck = 1'b1;
         #150;
         q = o_sel ? i_bus : {q[6:0], i_so};
         #50;
      end
   endtask : xb
   task rd(output logic [7:0] q);
      xb(~last, q);
   endtask : rd
   task close();
      if (!idle) o_sck = 1'b0;
      #250;
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      o_bus  = ~o_bus;
      #400;
   endtask : close
endmodule : fcp_host

// ===== dual_mode_flash_cmd_port_test.sv
// Purpose: Self-checking bench of the flash command port.
// Assumes: Memory answers with a pattern made from its address.
// Notes:   Busy counts are shortened through parameters.
`timescale 1ns/10ps
`include "fcp_consts.svh"
module dual_mode_flash_cmd_port_test;
   localparam int XFR  = 20;
   localparam int PROG = 40;
   localparam logic [7:0] LOAD_OP = 8'h1f;
   logic        clk;
   logic        rst_n;
   logic        ack;
   logic        slow;
   logic [7:0]  mdata;
   logic [7:0]  q;
   wire         cs_n, sck, si, sel, so, so_oe, bus_oe, rdy, req;
   wire  [7:0]  hbus, obus, bwire;
   wire  [1:0]  src;
   wire  [24:0] maddr;
   wire  [6:0]  sec;
   int          n_fail = 0;
   int          checked = 0;
   // ***************************************************************
   // Design, host model, memory and scenarios.
   // ***************************************************************
   assign bwire = bus_oe ? obus : hbus;
   fcp_cmd_port #(.XFR_CYCLES(XFR), .PROG_CYCLES(PROG)) i_fcp_cmd_port (
      .I_MCLK(clk), .I_RESETN(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si),
      .I_BUS(bwire), .I_IFSEL_BYTE(sel), .I_MEM_ACK(ack), .I_MEM_DATA(mdata),
      .O_SO(so), .O_SO_OE(so_oe), .O_BUS(obus), .O_BUS_OE(bus_oe),
      .O_RDY_BUSY_N(rdy), .O_MEM_REQ(req), .O_MEM_SRC(src), .O_MEM_ADDR(maddr),
      .O_SECTOR(sec));
   fcp_host i_fcp_host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_bus(hbus),
      .o_sel(sel), .i_so(so), .i_bus(bwire));
   function automatic logic [7:0] mval(input logic [13:0] p, input logic [10:0] b,
                                       input logic [1:0] s);
      return b[7:0] ^ p[7:0] ^ {s, 6'h00};
   endfunction : mval
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk) begin
      ack   <= !slow || !ack;
      mdata <= mval(maddr[24:11], maddr[10:0], src);
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cmd(input logic hi, bm, input logic [7:0] op, input logic [24:0] a, input int na, nd);
      i_fcp_host.open(hi, bm);
      i_fcp_host.xb(op, q);
      for (int i = 3; i >= 4 - na; i--) i_fcp_host.xb(8'({7'h0, a} >> (8 * i)), q);
      repeat (nd) i_fcp_host.xb(8'h00, q);
   endtask : cmd
   task rdx(input string nm, input logic [7:0] e);
      i_fcp_host.rd(q);
      chk(nm, e, q);
   endtask : rdx
   task t_status();
      cmd(1'b0, 1'b0, `FCP_OP_STATUS, 25'h0, 0, 0);
      rdx("status", {1'b1, 7'h3c});
      rdx("status", {1'b1, 7'h3c});
      i_fcp_host.close();
      cmd(1'b1, 1'b1, `FCP_OP_STATUS, 25'h0, 0, 0);
      rdx("status_byte", {1'b1, 7'h3c});
      i_fcp_host.close();
   endtask : t_status
   task t_id();
      logic [7:0] ids [4];
      ids = '{8'h5a, 8'h11, 8'h22, 8'h00};
      cmd(1'b1, 1'b0, `FCP_OP_ID, 25'h0, 0, 0);
      foreach (ids[i]) rdx("id", ids[i]);
      i_fcp_host.close();
   endtask : t_id
   task t_buf();
      logic [7:0] ops [4];
      ops = '{`FCP_OP_BUF1_SER, `FCP_OP_BUF2_SER, `FCP_OP_BUF1_BYTE, `FCP_OP_BUF2_BYTE};
      for (int k = 0; k < 4; k++) begin
         cmd(k[0], k[1], ops[k], {14'h5, 11'h41e}, 4, 1);
         chk("bus_oe", 8'h0, {7'h0, bus_oe});
         rdx("buf", mval(14'h5, 11'h41e, {1'b0, k[0]}));
         rdx("buf", mval(14'h5, 11'h41f, {1'b0, k[0]}));
         rdx("buf_wrap", mval(14'h5, 11'h0, {1'b0, k[0]}));
         i_fcp_host.close();
      end
   endtask : t_buf
   task t_page();
      cmd(1'b0, 1'b0, `FCP_OP_PAGE, {14'h3, 11'h41e}, 4, 4);
      rdx("page", mval(14'h3, 11'h41e, 2'h2));
      rdx("page", mval(14'h3, 11'h41f, 2'h2));
      rdx("page_wrap", mval(14'h3, 11'h0, 2'h2));
      i_fcp_host.close();
   endtask : t_page
   task t_array();
      slow = 1'b1;
      cmd(1'b1, 1'b1, `FCP_OP_ARRAY, {14'h3, 11'h41e}, 4, 4);
      for (int i = 0; i < 10; i++) begin
         rdx("array", i < 2 ? mval(14'h3, 11'h41e + 11'(i), 2'h2)
                            : mval(14'h4, 11'(i - 2), 2'h2));
      end
      i_fcp_host.close();
      slow = 1'b0;
   endtask : t_array
   task t_sector();
      logic [13:0] pg [5];
      logic [6:0]  ex [5];
      pg = '{14'h0007, 14'h0008, 14'h0100, 14'h3c05, 14'h3fff};
      ex = '{7'h00, 7'h01, 7'h02, 7'h3d, 7'h40};
      for (int k = 0; k < 5; k++) begin
         cmd(1'b0, 1'b0, `FCP_OP_PAGE, {pg[k], 11'h0}, 4, 0);
         i_fcp_host.close();
         chk("sector", {1'b0, ex[k]}, {1'b0, sec});
      end
   endtask : t_sector
   task t_busy();
      logic [7:0] ops [2];
      int         lim [2];
      int         n;
      ops = '{`FCP_OP_XFR1, `FCP_OP_PROG1};
      lim = '{XFR, PROG};
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            cmd(1'b0, 1'b0, LOAD_OP, 25'h0, 4, 2);
            i_fcp_host.close();
            chk("load_ready", 8'h1, {7'h0, rdy});
         end
         cmd(1'b0, 1'b0, ops[k], 25'h0, 4, 0);
         i_fcp_host.close();
         chk("busy", 8'h0, {7'h0, rdy});
         n = 0;
         while (rdy !== 1'b1 && n < lim[k]) begin
            @(negedge clk);
            n++;
         end
         chk("ready", 8'h1, {7'h0, rdy});
      end
   endtask : t_busy
   task t_refuse();
      cmd(1'b0, 1'b1, `FCP_OP_BUF1_SER, 25'h0, 4, 1);
      i_fcp_host.rd(q);
      chk("wrong_mode_oe", 8'h0, {7'h0, bus_oe});
      i_fcp_host.close();
      cmd(1'b0, 1'b0, 8'h11, 25'h0, 4, 1);
      i_fcp_host.rd(q);
      chk("unknown_op_oe", 8'h0, {7'h0, so_oe});
      i_fcp_host.close();
   endtask : t_refuse
   task stop_test();
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   initial begin
      rst_n = 1'b0;
      slow  = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_status();
      t_id();
      t_buf();
      t_page();
      t_array();
      t_sector();
      t_busy();
      t_refuse();
      stop_test();
   end
   initial begin
      #3000000;
      n_fail++;
      stop_test();
   end
endmodule : dual_mode_flash_cmd_port_test
